// file: uart_pkg.sv
// Shared constants and types for the serial channel receive, baud and modem status block.
package uart_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_RXBUF = 8'h00;
  localparam logic [7:0] OFF_IER   = 8'h04;
  localparam logic [7:0] OFF_FCR   = 8'h08;
  localparam logic [7:0] OFF_LCTL  = 8'h0c;
  localparam logic [7:0] OFF_MCTL  = 8'h10;
  localparam logic [7:0] OFF_LSR   = 8'h14;
  localparam logic [7:0] OFF_MSTAT = 8'h18;
  localparam logic [7:0] OFF_SCR   = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IER_RXD    = 0;
  localparam int IER_MODEM  = 3;
  localparam int FCR_EN     = 0;
  localparam int FCR_RXRST  = 1;
  localparam int FCR_TRIG   = 6;
  localparam int LCTL_PAREN  = 3;
  localparam int LCTL_EVEN   = 4;
  localparam int LCTL_STICK  = 5;
  localparam int LCTL_DIVACC = 7;
  localparam int MCTL_DTR    = 0;
  localparam int MCTL_RTS    = 1;
  localparam int MCTL_OUTA   = 2;
  localparam int MCTL_OUTB   = 3;
  localparam int MCTL_LOOP   = 4;
  localparam int MCTL_AFE    = 5;

  // ----------------------------------------------------------------
  // Reset values, sizes and sampling counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_DIV    = 16'h0000;
  localparam logic [4:0]  FIFO_DEPTH = 5'h10;
  localparam logic [4:0]  HOLD_DEPTH = 5'h01;
  localparam logic [3:0]  MID_START  = 4'h7;
  localparam logic [3:0]  MID_BIT    = 4'hf;
  localparam logic [2:0]  MIN_BITS   = 3'h4;
  localparam logic [4:0]  TRIG_LVL [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic       perr;
    logic       ferr;
  } rx_char_s;

endpackage : uart_pkg

// file: baud_gen.sv
// Programmable divider producing the sixteen-times sampling tick.
`timescale 1ns/1ps
`default_nettype none
module baud_gen (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Reference and divisor
  input  wire logic        ref_in,
  input  wire logic [15:0] divisor,
  input  wire logic        load,
  // Sampling tick
  output logic             tick
);

  logic        ref_d_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;
  logic        ref_rise;

  assign ref_rise = ref_in & ~ref_d_r;
  assign tick     = tick_r;

  // A zero divisor is not a legal setting; the generator then stays silent.
  always_comb
  begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (load)
    begin
      cnt_nxt = 16'h0000;
    end
    else if (ref_rise && divisor != 16'h0000)
    begin
      if (cnt_r + 16'h0001 >= divisor)
      begin
        cnt_nxt  = 16'h0000;
        tick_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_d_r <= 1'b0;
      cnt_r   <= 16'h0000;
      tick_r  <= 1'b0;
    end
    else
    begin
      ref_d_r <= ref_in;
      cnt_r   <= cnt_nxt;
      tick_r  <= tick_nxt;
    end
  end

  a_baud_reload: assert property (@(posedge clk) disable iff (!rst_n)
    load |=> (cnt_r == 16'h0000) && !tick_r)
    else $error("baud counter not reloaded on divisor write");

  a_baud_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    (tick_r && divisor > 16'h0001 && !load) |-> !tick_nxt)
    else $error("baud ticks closer than the divisor allows");

endmodule : baud_gen
`default_nettype wire

// file: rx_shifter.sv
// Receive shift register: start detect, data, parity and stop sampling.
`timescale 1ns/1ps
`default_nettype none
module rx_shifter (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Line and timing
  input  wire logic             rx_in,
  input  wire logic             tick,
  input  wire logic [7:0]       lctl,
  // Completed character
  output uart_pkg::rx_char_s    rx_char,
  output logic                  rx_valid
);

  uart_pkg::rx_state_e state_r, state_nxt;
  logic [3:0]          tcnt_r, tcnt_nxt;
  logic [2:0]          bit_r, bit_nxt;
  uart_pkg::rx_char_s  char_r, char_nxt;
  logic                valid_r, valid_nxt;
  logic [2:0]          last_bit;

  assign last_bit = uart_pkg::MIN_BITS + {1'b0, lctl[1:0]};
  assign rx_char  = char_r;
  assign rx_valid = valid_r;

  always_comb
  begin
    state_nxt = state_r;
    tcnt_nxt  = tcnt_r;
    bit_nxt   = bit_r;
    char_nxt  = char_r;
    valid_nxt = 1'b0;
    unique case (state_r)
      uart_pkg::RX_IDLE:
      begin
        if (!rx_in)
        begin
          state_nxt = uart_pkg::RX_START;
          tcnt_nxt  = 4'h0;
          char_nxt  = '0;
        end
      end
      uart_pkg::RX_START:
      begin
        if (tick)
        begin
          tcnt_nxt = tcnt_r + 4'h1;
          if (tcnt_r == uart_pkg::MID_START)
          begin
            // A start bit that is high again at mid-bit was a glitch.
            state_nxt = rx_in ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
            tcnt_nxt  = 4'h0;
            bit_nxt   = 3'h0;
          end
        end
      end
      uart_pkg::RX_DATA:
      begin
        if (tick)
        begin
          tcnt_nxt = tcnt_r + 4'h1;
          if (tcnt_r == uart_pkg::MID_BIT)
          begin
            char_nxt.data[bit_r] = rx_in;
            bit_nxt = bit_r + 3'h1;
            if (bit_r == last_bit)
            begin
              state_nxt = lctl[uart_pkg::LCTL_PAREN] ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
            end
          end
        end
      end
      uart_pkg::RX_PAR:
      begin
        if (tick)
        begin
          tcnt_nxt = tcnt_r + 4'h1;
          if (tcnt_r == uart_pkg::MID_BIT)
          begin
            if (lctl[uart_pkg::LCTL_STICK])
              char_nxt.perr = rx_in ^ ~lctl[uart_pkg::LCTL_EVEN];
            else
              char_nxt.perr = (^char_r.data) ^ rx_in ^ ~lctl[uart_pkg::LCTL_EVEN];
            state_nxt = uart_pkg::RX_STOP;
          end
        end
      end
      uart_pkg::RX_STOP:
      begin
        if (tick)
        begin
          tcnt_nxt = tcnt_r + 4'h1;
          if (tcnt_r == uart_pkg::MID_BIT)
          begin
            char_nxt.ferr = ~rx_in;
            valid_nxt     = 1'b1;
            state_nxt     = uart_pkg::RX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= uart_pkg::RX_IDLE;
      tcnt_r  <= 4'h0;
      bit_r   <= 3'h0;
      char_r  <= '0;
      valid_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tcnt_r  <= tcnt_nxt;
      bit_r   <= bit_nxt;
      char_r  <= char_nxt;
      valid_r <= valid_nxt;
    end
  end

  a_rx_false_start: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == uart_pkg::RX_START && tick && tcnt_r == uart_pkg::MID_START && rx_in)
    |=> state_r == uart_pkg::RX_IDLE)
    else $error("false start bit not rejected");

endmodule : rx_shifter
`default_nettype wire

// file: uart_msr_baud_rx.sv
// Serial channel top: APB registers, modem status, receive buffer and scratch.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module uart_modem_status_baud_rx (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Modem inputs, active low
  input  wire logic        CTS_N,
  input  wire logic        DSR_N,
  input  wire logic        RI_N,
  input  wire logic        DCD_N,
  // Serial receive and reference clock
  input  wire logic        SIN,
  input  wire logic        REF_CLK_IN,
  // Interrupt requests
  output logic             RX_DATA_IRQ,
  output logic             MODEM_IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  dll_r, dll_nxt, dlm_r, dlm_nxt;
  logic [7:0]  ier_r, ier_nxt, fcr_r, fcr_nxt;
  logic [7:0]  lctl_r, lctl_nxt, mctl_r, mctl_nxt, scr_r, scr_nxt;
  logic [3:0]  delta_r, delta_nxt, line_r, line_nxt;
  logic [2:0]  err_r, err_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic        rxirq_r, rxirq_nxt, mdirq_r, mdirq_nxt;
  logic [7:0]  mem_r [16];
  logic [7:0]  mem_nxt [16];
  logic [3:0]  wp_r, wp_nxt, rp_r, rp_nxt;
  logic [4:0]  cnt_r, cnt_nxt;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        setup, acc, wr, rd, divisor_access_bit, mapped;
  logic [31:0] rd_data;
  logic [3:0]  line_now, evt;
  logic        afe, fifo_en, push, pop, ovr, flush, div_load;
  logic [4:0]  limit;
  logic        tick;
  logic        rx_line;
  uart_pkg::rx_char_s rx_char;
  logic        rx_valid;

  assign setup  = PSEL & ~PENABLE;
  assign acc    = PSEL & PENABLE & pready_r;
  assign wr     = acc & PWRITE;
  assign rd     = acc & ~PWRITE;
  assign divisor_access_bit   = lctl_r[uart_pkg::LCTL_DIVACC];
  assign mapped = (PADDR[1:0] == 2'b00) && (PADDR <= uart_pkg::OFF_SCR);

  assign PRDATA      = prdata_r;
  assign PREADY      = pready_r;
  assign PSLVERR     = pslverr_r;
  assign RX_DATA_IRQ = rxirq_r;
  assign MODEM_IRQ   = mdirq_r;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (PADDR)
      uart_pkg::OFF_RXBUF: rd_data[7:0] = divisor_access_bit ? dll_r : mem_r[rp_r];
      uart_pkg::OFF_IER:   rd_data[7:0] = divisor_access_bit ? dlm_r : ier_r;
      uart_pkg::OFF_FCR:   rd_data[7:0] = fcr_r;
      uart_pkg::OFF_LCTL:  rd_data[7:0] = lctl_r;
      uart_pkg::OFF_MCTL:  rd_data[7:0] = mctl_r;
      uart_pkg::OFF_LSR:   rd_data[7:0] = {4'h0, err_r, cnt_r != 5'h00};
      uart_pkg::OFF_MSTAT: rd_data[7:0] = {line_r, delta_r};
      uart_pkg::OFF_SCR:   rd_data[7:0] = scr_r;
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer: data is captured in setup, access ends one cycle later
  // ----------------------------------------------------------------
  always_comb
  begin
    pready_nxt  = setup;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup)
    begin
      prdata_nxt  = PWRITE ? 32'h0000_0000 : rd_data;
      pslverr_nxt = ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_comb
  begin
    dll_nxt  = dll_r;
    dlm_nxt  = dlm_r;
    ier_nxt  = ier_r;
    fcr_nxt  = fcr_r;
    lctl_nxt = lctl_r;
    mctl_nxt = mctl_r;
    scr_nxt  = scr_r;
    div_load = 1'b0;
    flush    = 1'b0;
    if (wr)
    begin
      unique case (PADDR)
        uart_pkg::OFF_RXBUF:
        begin
          if (divisor_access_bit)
          begin
            dll_nxt  = PWDATA[7:0];
            div_load = 1'b1;
          end
        end
        uart_pkg::OFF_IER:
        begin
          if (divisor_access_bit)
          begin
            dlm_nxt  = PWDATA[7:0];
            div_load = 1'b1;
          end
          else
            ier_nxt = PWDATA[7:0];
        end
        uart_pkg::OFF_FCR:
        begin
          // Changing FIFO mode or asking for a receive reset empties the buffer.
          flush   = PWDATA[uart_pkg::FCR_RXRST] |
                    (PWDATA[uart_pkg::FCR_EN] ^ fcr_r[uart_pkg::FCR_EN]);
          fcr_nxt = {PWDATA[7:6], 5'h00, PWDATA[uart_pkg::FCR_EN]};
        end
        uart_pkg::OFF_LCTL: lctl_nxt = PWDATA[7:0];
        uart_pkg::OFF_MCTL: mctl_nxt = {2'b00, PWDATA[5:0]};
        uart_pkg::OFF_SCR: scr_nxt = PWDATA[7:0];
        default:           scr_nxt = scr_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Modem status
  // ----------------------------------------------------------------
  assign afe = mctl_r[uart_pkg::MCTL_AFE];

  always_comb
  begin
    if (mctl_r[uart_pkg::MCTL_LOOP])
      line_now = {mctl_r[uart_pkg::MCTL_OUTB], mctl_r[uart_pkg::MCTL_OUTA],
                  mctl_r[uart_pkg::MCTL_DTR], mctl_r[uart_pkg::MCTL_RTS]};
    else
      line_now = ~{DCD_N, RI_N, DSR_N, CTS_N};
    evt[0] = (line_now[0] ^ line_r[0]) & ~afe;
    evt[1] = line_now[1] ^ line_r[1];
    evt[2] = line_r[2] & ~line_now[2];
    evt[3] = line_now[3] ^ line_r[3];
    line_nxt  = line_now;
    delta_nxt = delta_r;
    // Only bits that the read reported are cleared, so a change that
    // lands between setup and access still shows on the next read.
    if (rd && PADDR == uart_pkg::OFF_MSTAT)
      delta_nxt = delta_r & ~prdata_r[3:0];
    delta_nxt = delta_nxt | evt;
    if (afe)
      delta_nxt[0] = 1'b0;
    mdirq_nxt = ier_r[uart_pkg::IER_MODEM] & (|delta_r);
  end

  // ----------------------------------------------------------------
  // Baud generator and receive shifter
  // ----------------------------------------------------------------
  // Loopback disconnects the receive pin and holds the line at mark.
  assign rx_line = mctl_r[uart_pkg::MCTL_LOOP] | SIN;

  baud_gen i_baud_gen (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .ref_in  (REF_CLK_IN),
    .divisor ({dlm_r, dll_r}),
    .load    (div_load),
    .tick    (tick)
  );

  rx_shifter i_rx_shifter (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .rx_in    (rx_line),
    .tick     (tick),
    .lctl     (lctl_r),
    .rx_char  (rx_char),
    .rx_valid (rx_valid)
  );

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  assign fifo_en = fcr_r[uart_pkg::FCR_EN];
  assign limit   = fifo_en ? uart_pkg::FIFO_DEPTH : uart_pkg::HOLD_DEPTH;
  assign push    = rx_valid;
  assign pop     = rd & (PADDR == uart_pkg::OFF_RXBUF) & ~divisor_access_bit & (cnt_r != 5'h00);
  assign ovr     = push & ~pop & (cnt_r == limit);

  always_comb
  begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    err_nxt = err_r;
    if (rd && PADDR == uart_pkg::OFF_LSR)
      err_nxt = err_r & ~prdata_r[3:1];
    if (flush)
    begin
      wp_nxt  = 4'h0;
      rp_nxt  = 4'h0;
      cnt_nxt = 5'h00;
    end
    else
    begin
      if (push && !ovr)
      begin
        mem_nxt[wp_r] = rx_char.data;
        wp_nxt = wp_r + 4'h1;
      end
      else if (ovr && !fifo_en)
        mem_nxt[rp_r] = rx_char.data; // Holding register is overwritten.
      if (pop)
        rp_nxt = rp_r + 4'h1;
      cnt_nxt = cnt_r + {4'h0, push & ~ovr} - {4'h0, pop};
    end
    if (push)
      err_nxt = err_nxt | {rx_char.ferr, rx_char.perr, ovr};
    if (fifo_en)
      rxirq_nxt = ier_r[uart_pkg::IER_RXD] &
                  (cnt_r >= uart_pkg::TRIG_LVL[fcr_r[7:uart_pkg::FCR_TRIG]]);
    else
      rxirq_nxt = ier_r[uart_pkg::IER_RXD] & (cnt_r != 5'h00);
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_mem
      always_ff @(posedge CORE_CLK or negedge RST_N)
      begin
        if (!RST_N)
          mem_r[gi] <= uart_pkg::RST_BYTE;
        else
          mem_r[gi] <= mem_nxt[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      dll_r     <= uart_pkg::RST_DIV[7:0];
      dlm_r     <= uart_pkg::RST_DIV[15:8];
      ier_r     <= uart_pkg::RST_BYTE;
      fcr_r     <= uart_pkg::RST_BYTE;
      lctl_r    <= uart_pkg::RST_BYTE;
      mctl_r    <= uart_pkg::RST_BYTE;
      scr_r     <= uart_pkg::RST_BYTE;
      delta_r   <= 4'h0;
      line_r    <= 4'h0;
      err_r     <= 3'h0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      rxirq_r   <= 1'b0;
      mdirq_r   <= 1'b0;
      wp_r      <= 4'h0;
      rp_r      <= 4'h0;
      cnt_r     <= 5'h00;
    end
    else
    begin
      dll_r     <= dll_nxt;
      dlm_r     <= dlm_nxt;
      ier_r     <= ier_nxt;
      fcr_r     <= fcr_nxt;
      lctl_r    <= lctl_nxt;
      mctl_r    <= mctl_nxt;
      scr_r     <= scr_nxt;
      delta_r   <= delta_nxt;
      line_r    <= line_nxt;
      err_r     <= err_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      rxirq_r   <= rxirq_nxt;
      mdirq_r   <= mdirq_nxt;
      wp_r      <= wp_nxt;
      rp_r      <= rp_nxt;
      cnt_r     <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_mstat_read_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (rd && PADDR == uart_pkg::OFF_MSTAT && evt == 4'h0)
    |=> (delta_r & $past(prdata_r[3:0])) == 4'h0)
    else $error("modem status read did not clear change bits");

  a_cts_change_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (line_now[0] != line_r[0] && !afe) |=> delta_r[0])
    else $error("clear-to-send change not flagged");

  a_cts_afe_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    afe |=> !delta_r[0])
    else $error("clear-to-send change flagged under autoflow");

  a_dsr_change_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (line_now[1] != line_r[1]) |=> delta_r[1])
    else $error("data-set-ready change not flagged");

  a_ring_trailing: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (!delta_r[2] && !(line_r[2] && !line_now[2])) |=> !delta_r[2])
    else $error("ring bit set without a trailing edge");

  a_dcd_change_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (line_now[3] != line_r[3]) |=> delta_r[3])
    else $error("carrier change not flagged");

  a_status_pins: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !mctl_r[uart_pkg::MCTL_LOOP] |=> line_r == ~$past({DCD_N, RI_N, DSR_N, CTS_N}))
    else $error("status bits do not follow inverted modem inputs");

  a_loop_source: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    mctl_r[uart_pkg::MCTL_LOOP] |=> line_r == {$past(mctl_r[3]), $past(mctl_r[2]),
                                               $past(mctl_r[0]), $past(mctl_r[1])})
    else $error("loopback status not taken from modem control");

  a_fifo_bounded: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    cnt_r <= uart_pkg::FIFO_DEPTH && (cnt_r <= limit || $past(flush) || $past(fifo_en)))
    else $error("receive buffer count above its depth");

  a_rx_irq_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (!fifo_en && ier_r[uart_pkg::IER_RXD] && cnt_r != 5'h00) |=> RX_DATA_IRQ)
    else $error("received-data interrupt missing");

  a_scratch_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (wr && PADDR == uart_pkg::OFF_SCR) |=> scr_r == $past(PWDATA[7:0]))
    else $error("scratch register did not store the write");

endmodule : uart_modem_status_baud_rx
`default_nettype wire

// file: modem_partner.sv
// Modem-side model: modem line levels, serial sender and reference clock.
`timescale 1ns/1ps
`default_nettype none
module modem_partner (
  // Clock
  input  wire logic clk,
  // Modem lines, serial data and reference
  output logic      cts_n,
  output logic      dsr_n,
  output logic      ri_n,
  output logic      dcd_n,
  output logic      sin,
  output logic      ref_clk
);
  logic [1:0] cnt;
  initial {cnt, cts_n, dsr_n, ri_n, dcd_n, sin} = 7'h1f;
  always @(posedge clk) cnt <= cnt + 2'h1;
  // The reference runs at a quarter of clk, well under the half-rate limit.
  assign ref_clk = cnt[1];
  task automatic set_lines(input logic [3:0] v);
    @(posedge clk);
    {dcd_n, ri_n, dsr_n, cts_n} <= v;
  endtask : set_lines
  // One bit is sixteen ticks, and one tick is div reference periods of four clk.
  task automatic send_byte(input logic [7:0] d, input int div);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      sin <= f[i];
      repeat (64 * div - 1) @(posedge clk);
    end
  endtask : send_byte
endmodule : modem_partner
`default_nettype wire

// file: uart_msr_baud_rx_tb.sv
// Self-checking testbench for the modem status, baud and receive block.
`timescale 1ns/1ps
`default_nettype none
module uart_modem_status_baud_rx_tb;
  logic        core_clk = 1'b0;
  logic        rst_n;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rerr, rx_irq, modem_irq;
  logic        cts_n, dsr_n, ri_n, dcd_n, sin, ref_clk;
  int          n_mismatch = 0;
  int          compares = 0;
  always #12.5 core_clk = ~core_clk;
  uart_modem_status_baud_rx i_uart_modem_status_baud_rx (.CORE_CLK(core_clk), .RST_N(rst_n),
    .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CTS_N(cts_n), .DSR_N(dsr_n), .RI_N(ri_n),
    .DCD_N(dcd_n), .SIN(sin), .REF_CLK_IN(ref_clk), .RX_DATA_IRQ(rx_irq),
    .MODEM_IRQ(modem_irq));
  modem_partner i_modem_partner (.clk(core_clk), .cts_n(cts_n), .dsr_n(dsr_n),
    .ri_n(ri_n), .dcd_n(dcd_n), .sin(sin), .ref_clk(ref_clk));
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
    if (pready !== 1'b1)
    begin
      $display("Error %0t bus answer timed out", $time);
      n_mismatch++;
    end
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("Error %0t got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic lines(input logic [3:0] v);
    i_modem_partner.set_lines(v);
    repeat (10) @(posedge core_clk);
  endtask : lines
  task automatic t_reset;
    apb(0, uart_pkg::OFF_MSTAT, 0); chk(rdat, 0);
    chk(modem_irq, 0);
    apb(0, 8'h20, 0); chk(rerr, 1);
    apb(1, uart_pkg::OFF_SCR, 8'ha5); apb(0, uart_pkg::OFF_SCR, 0); chk(rdat, 32'ha5);
    apb(0, uart_pkg::OFF_MSTAT, 0); chk(rdat, 0);
    $display("reset and scratch test done");
  endtask : t_reset
  task automatic t_modem;
    apb(1, uart_pkg::OFF_IER, 8'h08);
    lines(4'h0); chk(modem_irq, 1);
    apb(0, uart_pkg::OFF_MSTAT, 0); chk(rdat, 32'hfb);
    apb(0, uart_pkg::OFF_MSTAT, 0); chk(rdat, 32'hf0);
    repeat (2) @(posedge core_clk);
    chk(modem_irq, 0);
    lines(4'hf); apb(0, uart_pkg::OFF_MSTAT, 0); chk(rdat, 32'h0f);
    apb(1, uart_pkg::OFF_MCTL, 8'h20);
    lines(4'he); apb(0, uart_pkg::OFF_MSTAT, 0); chk(rdat, 32'h10);
    lines(4'hf); apb(1, uart_pkg::OFF_MCTL, 8'h15); apb(1, uart_pkg::OFF_MCTL, 8'h15);
    apb(0, uart_pkg::OFF_MSTAT, 0); chk(rdat[7:4], 4'h6);
    apb(1, uart_pkg::OFF_MCTL, 8'h00); apb(1, uart_pkg::OFF_IER, 8'h00);
    $display("modem status test done");
  endtask : t_modem
  task automatic t_rx;
    int n;
    n = 0;
    apb(1, uart_pkg::OFF_LCTL, 8'h83);
    apb(1, uart_pkg::OFF_RXBUF, 8'h01); apb(1, uart_pkg::OFF_IER, 8'h00);
    apb(1, uart_pkg::OFF_LCTL, 8'h03); apb(1, uart_pkg::OFF_IER, 8'h01);
    i_modem_partner.send_byte(8'h5a, 1);
    while (rx_irq !== 1'b1 && ++n < 300) @(posedge core_clk);
    chk(rx_irq, 1);
    apb(0, uart_pkg::OFF_RXBUF, 0); chk(rdat, 32'h5a);
    repeat (2) @(posedge core_clk);
    chk(rx_irq, 0);
    $display("receive test done");
  endtask : t_rx
  task automatic t_fifo;
    apb(1, uart_pkg::OFF_LCTL, 8'h83); apb(1, uart_pkg::OFF_RXBUF, 8'h03);
    apb(1, uart_pkg::OFF_LCTL, 8'h03); apb(1, uart_pkg::OFF_FCR, 8'h41);
    i_modem_partner.send_byte(8'h31, 3);
    i_modem_partner.send_byte(8'h32, 3);
    i_modem_partner.send_byte(8'h33, 3);
    chk(rx_irq, 0);
    i_modem_partner.send_byte(8'hc3, 3);
    chk(rx_irq, 1);
    apb(0, uart_pkg::OFF_RXBUF, 0); chk(rdat, 32'h31);
    apb(0, uart_pkg::OFF_RXBUF, 0); chk(rdat, 32'h32);
    apb(0, uart_pkg::OFF_RXBUF, 0); chk(rdat, 32'h33);
    apb(0, uart_pkg::OFF_RXBUF, 0); chk(rdat, 32'hc3);
    apb(0, uart_pkg::OFF_LSR, 0); chk(rdat, 32'h00);
    $display("fifo receive test done");
  endtask : t_fifo
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial
  begin
    #500000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_modem();
    t_rx();
    t_fifo();
    complete_run();
  end
endmodule : uart_modem_status_baud_rx_tb
`default_nettype wire
